// >>> rtl/mie_pkg.sv
package mie_pkg;

  // Operation classes presented by the fetch stage.
  typedef enum logic [4:0] {
    OP_IDLE       = 5'h00,
    OP_MOV_M2A    = 5'h01,
    OP_MOV_A2M    = 5'h02,
    OP_MOV_X2A    = 5'h03,
    OP_BIT_CLR    = 5'h04,
    OP_BIT_SET    = 5'h05,
    OP_GOTO       = 5'h06,
    OP_SKZ        = 5'h07,
    OP_SKZ_COPY   = 5'h08,
    OP_SKB_CLR    = 5'h09,
    OP_SKB_SET    = 5'h0a,
    OP_INC_SKZ    = 5'h0b,
    OP_DEC_SKZ    = 5'h0c,
    OP_INC_SKZ_A  = 5'h0d,
    OP_DEC_SKZ_A  = 5'h0e,
    OP_CALL       = 5'h0f,
    OP_RET        = 5'h10,
    OP_RET_X      = 5'h11,
    OP_INTERRUPT_EXIT       = 5'h12,
    OP_TAB_PAGED  = 5'h13,
    OP_TAB_CUR    = 5'h14,
    OP_TAB_LAST   = 5'h15,
    OP_BYTE_CLR   = 5'h16,
    OP_BYTE_SET   = 5'h17,
    OP_WDT_CLR    = 5'h18,
    OP_WDT_PRE_A  = 5'h19,
    OP_WDT_PRE_B  = 5'h1a,
    OP_SWAP       = 5'h1b,
    OP_SWAP_A     = 5'h1c,
    OP_HALT       = 5'h1d,
    OP_ADC        = 5'h1e,
    OP_ADD        = 5'h1f
  } mie_op_t;

  // Destination and operand selection for the add and AND groups.
  typedef struct packed {
    logic use_imm;
    logic to_mem;
    logic is_and;
  } mie_alu_sel_t;

  // One decoded instruction as handed over by fetch.
  typedef struct packed {
    mie_op_t op;
    mie_alu_sel_t sel;
    logic [2:0] bit_idx;
    logic [7:0] imm;
    logic [10:0] addr;
  } mie_instr_t;

  // Status flags of the core.
  typedef struct packed {
    logic ovf;
    logic zero;
    logic half;
    logic carry;
    logic tmo;
    logic pdn;
  } mie_flags_t;

  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hff;
  localparam logic [10:0] PC_RESET = 11'h000;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [5:0] FLAGS_RESET = 6'h00;
  localparam int PC_LOW_WIDTH = 8;

  // Pre-clear alternation tracker states.
  typedef enum logic [1:0] {
    PRE_NONE = 2'h0,
    PRE_A    = 2'h1,
    PRE_B    = 2'h2
  } mie_pre_t;

endpackage

// >>> rtl/mie_core.sv
// Operation
// [RL1] Moves copy memory to acc, acc to memory, or immediate to acc, one cycle.
// [RL2] Bit clear/set forces only bit i of the addressed byte.
// [RL3] Call pushes pc plus one, then loads target; two cycles.
// [RL4] Goto and all returns take two cycles, flags untouched.
// [RL5] Skip takes two cycles when skipping, one otherwise.
// [RL6] Writing the low program counter byte costs two cycles.
// [RL7] Zero skips test byte or bit; copy variant also loads acc.
// [RL8] Increment/decrement skip on zero result; acc variants keep memory.
// [RL9] Table fetches read page word: high to latch, low to memory.
// [RL10] Byte clear writes 00H, byte set writes all ones.
// [RL11] Swap exchanges nibbles in place or into acc.
// [RL12] Watchdog clear resets counter and clears both flags.
// [RL13] Pre-clears act only after both run in alternation.
// [RL14] Carry sum adds acc, byte and carry; updates four flags.
// [RL15] Plain add without carry in; updates four flags.
// [RL16] AND forms update only the zero flag.
// [RL17] Idle does nothing; halt completes in one cycle.
// [RL18] Halt stops clock, clears watchdog and prescaler, sets powerdown.
// [RL19] Interrupt return restores pc and sets the global gate.
// [RL20] Zero, carry, half carry and overflow follow the result.
// [RL21] Two-cycle instructions insert one dummy cycle.
`timescale 1ns/1ns
module mie_core #(
  parameter int PC_W = 11,
  parameter int STACK_DEPTH = 4,
  parameter int DMEM_AW = 8
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic instr_valid,
  input wire mie_pkg::mie_instr_t instr,
  input wire logic [7:0] mem_rdata,
  input wire logic [15:0] table_word,
  input wire logic [7:0] table_ptr,
  input wire logic [7:0] table_page,
  input wire logic wake,
  output logic instr_take,
  output logic [PC_W-1:0] pc,
  output logic mem_we,
  output logic [7:0] mem_wdata,
  output logic [7:0] acc,
  output logic [7:0] table_high_latch,
  output logic [PC_W-1:0] table_addr,
  output logic watchdog_counter_clr,
  output logic prescaler_clr,
  output logic global_irq_gate,
  output logic sys_clk_run,
  output logic timeout_flag,
  output logic powerdown_flag,
  output logic null_result_flag,
  output logic msb_outflow_flag,
  output logic half_carry_flag,
  output logic overflow_flag
);

  // Targets arrive as eleven bits and a page needs a bit above the pointer byte,
  // so the counter is refused outside nine to eleven bits.
  if (PC_W < 9 || PC_W > 11 || STACK_DEPTH < 1 || DMEM_AW < 1) begin : g_bad_params
    $error("mie_core: unsupported parameters");
  end

  localparam int SP_W = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;

  ////////////////////////////////////////////////////////////////////////////
  // State record.

  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic [7:0] acc;
    mie_pkg::mie_flags_t fl;
    logic [7:0] tbh;
    logic gate;
    logic halted;
    logic run; // Clock gate kept as its own flop so the pin never passes through logic.
    logic dummy;
    logic take;
    logic we;
    logic [7:0] wdata;
    logic wdt_clr;
    logic pre_clr;
    logic [PC_W-1:0] taddr;
    mie_pkg::mie_pre_t pre;
    logic [SP_W-1:0] sp;
    logic [STACK_DEPTH-1:0][PC_W-1:0] stk;
  } mie_state_t;

  mie_state_t s_q;
  mie_state_t s_d;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // The memory byte is read combinationally at the addressed location, so every
  // read-modify-write is computed in the issuing cycle. The write lands one clock
  // later, so the fetch side must not read that byte in the very next cycle.
  always_comb begin
    logic [8:0] sum;
    logic [4:0] low;
    logic [7:0] opnd;
    logic [7:0] res;
    logic [7:0] bmask;
    logic skip;
    logic exec;
    logic [SP_W-1:0] sp_pop;
    sum = 9'h000;
    low = 5'h00;
    opnd = 8'h00;
    res = 8'h00;
    bmask = 8'h00;
    skip = 1'b0;
    exec = 1'b0;
    sp_pop = '0;
    s_d = s_q;
    s_d.we = 1'b0;
    s_d.wdt_clr = 1'b0;
    s_d.pre_clr = 1'b0;
    s_d.take = 1'b0;
    s_d.dummy = 1'b0;
    bmask[instr.bit_idx] = 1'b1;
    sp_pop = s_q.sp - SP_W'(1);
    opnd = instr.sel.use_imm ? instr.imm : mem_rdata;
    // An instruction is accepted only while running and outside a filler cycle.
    exec = instr_valid && !s_q.halted && !s_q.dummy;
    if (s_q.halted) begin
      // Registers and memory are retained while stopped.
      if (wake) begin
        // Only wake brings the clock back; nothing else is touched on the way out.
        s_d.halted = 1'b0;
        s_d.run = 1'b1;
      end
    end else if (s_q.dummy) begin
      // Filler cycle: nothing of the following instruction is committed. [RL21]
      s_d.dummy = 1'b0;
    end else if (exec) begin
      s_d.take = 1'b1;
      s_d.pc = s_q.pc + PC_W'(1);
      case (instr.op)
        mie_pkg::OP_IDLE: begin
          s_d.pc = s_q.pc + PC_W'(1); // [RL17]
        end
        mie_pkg::OP_MOV_M2A: begin
          s_d.acc = mem_rdata; // [RL1]
        end
        mie_pkg::OP_MOV_A2M: begin
          s_d.we = 1'b1; // [RL1]
          s_d.wdata = s_q.acc;
        end
        mie_pkg::OP_MOV_X2A: begin
          s_d.acc = instr.imm; // [RL1]
        end
        mie_pkg::OP_BIT_CLR: begin
          s_d.we = 1'b1;
          s_d.wdata = mem_rdata & ~bmask; // [RL2]
        end
        mie_pkg::OP_BIT_SET: begin
          s_d.we = 1'b1;
          s_d.wdata = mem_rdata | bmask; // [RL2]
        end
        mie_pkg::OP_GOTO: begin
          s_d.pc = instr.addr[PC_W-1:0]; // [RL4]
          s_d.dummy = 1'b1;
        end
        mie_pkg::OP_SKZ: begin
          skip = (mem_rdata == mie_pkg::BYTE_ZERO); // [RL7]
        end
        mie_pkg::OP_SKZ_COPY: begin
          skip = (mem_rdata == mie_pkg::BYTE_ZERO); // [RL7]
          s_d.acc = mem_rdata;
        end
        mie_pkg::OP_SKB_CLR: begin
          skip = !mem_rdata[instr.bit_idx]; // [RL7]
        end
        mie_pkg::OP_SKB_SET: begin
          skip = mem_rdata[instr.bit_idx]; // [RL7]
        end
        mie_pkg::OP_INC_SKZ, mie_pkg::OP_INC_SKZ_A,
        mie_pkg::OP_DEC_SKZ, mie_pkg::OP_DEC_SKZ_A: begin
          if (instr.op == mie_pkg::OP_INC_SKZ || instr.op == mie_pkg::OP_INC_SKZ_A) begin
            res = mem_rdata + 8'h01;
          end else begin
            res = mem_rdata - 8'h01;
          end
          skip = (res == mie_pkg::BYTE_ZERO); // [RL8]
          if (instr.op == mie_pkg::OP_INC_SKZ || instr.op == mie_pkg::OP_DEC_SKZ) begin
            s_d.we = 1'b1;
            s_d.wdata = res;
          end else begin
            s_d.acc = res; // [RL8]
          end
        end
        mie_pkg::OP_CALL: begin
          s_d.stk[s_q.sp] = s_q.pc + PC_W'(1); // [RL3]
          s_d.sp = (s_q.sp == SP_W'(STACK_DEPTH - 1)) ? '0 : s_q.sp + SP_W'(1);
          s_d.pc = instr.addr[PC_W-1:0]; // [RL3]
          s_d.dummy = 1'b1;
        end
        mie_pkg::OP_RET, mie_pkg::OP_RET_X, mie_pkg::OP_INTERRUPT_EXIT: begin
          if (s_q.sp == '0) begin
            sp_pop = SP_W'(STACK_DEPTH - 1);
          end
          s_d.sp = sp_pop;
          s_d.pc = s_q.stk[sp_pop]; // [RL4]
          s_d.dummy = 1'b1;
          if (instr.op == mie_pkg::OP_RET_X) begin
            s_d.acc = instr.imm;
          end
          if (instr.op == mie_pkg::OP_INTERRUPT_EXIT) begin
            // Setting the gate lets a pending request vector before main code. [RL19]
            s_d.gate = 1'b1;
          end
        end
        mie_pkg::OP_TAB_PAGED, mie_pkg::OP_TAB_CUR, mie_pkg::OP_TAB_LAST: begin
          // The fetch side shows the word with the instruction; the filler covers its fetch. [RL9]
          if (instr.op == mie_pkg::OP_TAB_PAGED) begin
            s_d.taddr = PC_W'({table_page, table_ptr});
          end else if (instr.op == mie_pkg::OP_TAB_CUR) begin
            s_d.taddr = {s_q.pc[PC_W-1:8], table_ptr};
          end else begin
            s_d.taddr = {{(PC_W-8){1'b1}}, table_ptr};
          end
          s_d.tbh = table_word[15:8]; // [RL9]
          s_d.we = 1'b1;
          s_d.wdata = table_word[7:0];
          s_d.dummy = 1'b1;
        end
        mie_pkg::OP_BYTE_CLR: begin
          s_d.we = 1'b1;
          s_d.wdata = mie_pkg::BYTE_ZERO; // [RL10]
        end
        mie_pkg::OP_BYTE_SET: begin
          s_d.we = 1'b1;
          s_d.wdata = mie_pkg::BYTE_ONES; // [RL10]
        end
        mie_pkg::OP_WDT_CLR: begin
          s_d.wdt_clr = 1'b1; // [RL12]
          s_d.fl.tmo = 1'b0;
          s_d.fl.pdn = 1'b0;
          s_d.pre = mie_pkg::PRE_NONE;
        end
        mie_pkg::OP_WDT_PRE_A, mie_pkg::OP_WDT_PRE_B: begin
          // Only a change of partner completes the pair; repeats just rearm. [RL13]
          if ((instr.op == mie_pkg::OP_WDT_PRE_A && s_q.pre == mie_pkg::PRE_B) ||
              (instr.op == mie_pkg::OP_WDT_PRE_B && s_q.pre == mie_pkg::PRE_A)) begin
            s_d.wdt_clr = 1'b1;
            s_d.fl.tmo = 1'b0;
            s_d.fl.pdn = 1'b0;
            s_d.pre = mie_pkg::PRE_NONE;
          end else begin
            s_d.pre = (instr.op == mie_pkg::OP_WDT_PRE_A) ? mie_pkg::PRE_A : mie_pkg::PRE_B;
          end
        end
        mie_pkg::OP_SWAP: begin
          s_d.we = 1'b1;
          s_d.wdata = {mem_rdata[3:0], mem_rdata[7:4]}; // [RL11]
        end
        mie_pkg::OP_SWAP_A: begin
          s_d.acc = {mem_rdata[3:0], mem_rdata[7:4]}; // [RL11]
        end
        mie_pkg::OP_HALT: begin
          // The fetch side stops the system clock from sys_clk_run.
          s_d.halted = 1'b1; // [RL18]
          s_d.run = 1'b0;
          s_d.wdt_clr = 1'b1;
          s_d.pre_clr = 1'b1;
          s_d.fl.pdn = 1'b1; // [RL18]
          s_d.fl.tmo = 1'b0;
        end
        mie_pkg::OP_ADC, mie_pkg::OP_ADD: begin
          if (instr.sel.is_and) begin
            res = s_q.acc & opnd; // [RL16]
            s_d.fl.zero = (res == mie_pkg::BYTE_ZERO);
          end else begin
            // Carry enters only for the carry-sum form. [RL14] [RL15]
            low = {1'b0, s_q.acc[3:0]} + {1'b0, opnd[3:0]} +
                  {4'h0, (instr.op == mie_pkg::OP_ADC) && s_q.fl.carry};
            sum = {1'b0, s_q.acc} + {1'b0, opnd} +
                  {8'h00, (instr.op == mie_pkg::OP_ADC) && s_q.fl.carry};
            res = sum[7:0];
            s_d.fl.carry = sum[8]; // [RL20]
            s_d.fl.half = low[4];
            s_d.fl.ovf = (s_q.acc[7] == opnd[7]) && (res[7] != s_q.acc[7]);
            s_d.fl.zero = (res == mie_pkg::BYTE_ZERO); // [RL20]
          end
          if (instr.sel.to_mem) begin
            s_d.we = 1'b1; // [RL14]
            s_d.wdata = res;
          end else begin
            s_d.acc = res;
          end
        end
        default: begin
          s_d.pc = s_q.pc + PC_W'(1);
        end
      endcase
      if (skip) begin
        // The skipped word is consumed by the filler cycle. [RL5]
        s_d.pc = s_q.pc + PC_W'(2);
        s_d.dummy = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_q <= '0;
      s_q.pc <= mie_pkg::PC_RESET[PC_W-1:0];
      s_q.acc <= mie_pkg::ACC_RESET;
      s_q.fl <= mie_pkg::FLAGS_RESET;
      s_q.pre <= mie_pkg::PRE_NONE;
      s_q.run <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from the state record.

  // A data-memory write to the low pc byte is redirected by the fetch side,
  // which must hold off one issue; the core itself sees that as a goto. [RL6]
  // Keeping that decode outside leaves the core free of any data-memory map.
  assign instr_take = s_q.take;
  assign pc = s_q.pc;
  assign mem_we = s_q.we;
  assign mem_wdata = s_q.wdata;
  assign acc = s_q.acc;
  assign table_high_latch = s_q.tbh;
  assign table_addr = s_q.taddr;
  assign watchdog_counter_clr = s_q.wdt_clr;
  assign prescaler_clr = s_q.pre_clr;
  assign global_irq_gate = s_q.gate;
  assign sys_clk_run = s_q.run;
  assign timeout_flag = s_q.fl.tmo;
  assign powerdown_flag = s_q.fl.pdn;
  assign null_result_flag = s_q.fl.zero;
  assign msb_outflow_flag = s_q.fl.carry;
  assign half_carry_flag = s_q.fl.half;
  assign overflow_flag = s_q.fl.ovf;

endmodule

// >>> dv/mie_mem_model.sv
`timescale 1ns/1ns
// Data memory and table source on the far side of the core.
module mie_mem_model (
  input wire logic mclk,
  input wire mie_pkg::mie_instr_t instr,
  input wire logic mem_we,
  input wire logic [7:0] mem_wdata,
  input wire logic [7:0] table_ptr,
  input wire logic [7:0] table_page,
  output logic [7:0] mem_rdata,
  output logic [15:0] table_word
);
  logic [7:0] mem [256];
  logic [7:0] wa_q;
  // Each byte starts as its own address, so every expected value is easy to work out.
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i);
    end
  end
  assign mem_rdata = mem[instr.addr[7:0]];
  // Page and pointer both shape the word, so a wrong page shows in the high byte.
  assign table_word = {table_page ^ 8'h5a, ~table_ptr};
  // The core registers its write, so the address is held here for one cycle.
  always @(posedge mclk) begin
    wa_q <= instr.addr[7:0];
    if (mem_we) begin
      mem[wa_q] <= mem_wdata;
    end
  end
endmodule

// >>> dv/mie_core_monitor.sv
`timescale 1ns/1ns
module mie_core_monitor #(
  parameter int PC_W = 11
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic instr_valid,
  input wire mie_pkg::mie_instr_t instr,
  input wire logic [7:0] mem_rdata,
  input wire logic [15:0] table_word,
  input wire logic instr_take,
  input wire logic [PC_W-1:0] pc,
  input wire logic mem_we,
  input wire logic [7:0] mem_wdata,
  input wire logic [7:0] acc,
  input wire logic [7:0] table_high_latch,
  input wire logic watchdog_counter_clr,
  input wire logic prescaler_clr,
  input wire logic sys_clk_run,
  input wire logic timeout_flag,
  input wire logic powerdown_flag,
  input wire logic null_result_flag,
  input wire logic msb_outflow_flag
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Operand views taken apart here because $past is handed whole signals only.
  logic [7:0] bmask, swp, tw_hi, tw_lo;
  assign bmask = 8'h01 << instr.bit_idx;
  assign swp = {mem_rdata[3:0], mem_rdata[7:4]};
  assign tw_hi = table_word[15:8];
  assign tw_lo = table_word[7:0];
  a_halt_stops_clock: assert property (instr_valid && instr.op == mie_pkg::OP_HALT ##1 instr_take
    |-> !sys_clk_run && powerdown_flag && !timeout_flag && prescaler_clr && watchdog_counter_clr)
    else $error("halt entry wrong");
  a_wdt_clear_flags: assert property (instr_valid && instr.op == mie_pkg::OP_WDT_CLR ##1 instr_take
    |-> watchdog_counter_clr && !timeout_flag && !powerdown_flag) else $error("wdt clear wrong");
  a_move_imm_acc: assert property (instr_valid && instr.op == mie_pkg::OP_MOV_X2A ##1 instr_take
    |-> acc == $past(instr.imm) && $stable(null_result_flag) && $stable(msb_outflow_flag))
    else $error("immediate load wrong");
  a_call_two_cycle: assert property (instr_valid && instr.op == mie_pkg::OP_CALL ##1 instr_take
    |-> pc == $past(instr.addr) ##1 !instr_take) else $error("call wrong");
  a_skip_taken_two: assert property (instr_valid && instr.op == mie_pkg::OP_SKZ && mem_rdata == 8'h00
    ##1 instr_take |-> pc == PC_W'($past(pc) + 2) ##1 !instr_take) else $error("skip wrong");
  a_skip_none_one: assert property (instr_valid && instr.op == mie_pkg::OP_SKZ && mem_rdata != 8'h00
    ##1 instr_take |-> pc == PC_W'($past(pc) + 1)) else $error("no-skip wrong");
  a_bit_set_only: assert property (instr_valid && instr.op == mie_pkg::OP_BIT_SET ##1 instr_take
    |-> mem_we && mem_wdata == ($past(mem_rdata) | $past(bmask))) else $error("bit set wrong");
  a_byte_clr_zero: assert property (instr_valid && instr.op == mie_pkg::OP_BYTE_CLR ##1 instr_take
    |-> mem_we && mem_wdata == 8'h00 && $stable(null_result_flag)) else $error("byte clear wrong");
  a_swap_into_acc: assert property (instr_valid && instr.op == mie_pkg::OP_SWAP_A ##1 instr_take
    |-> acc == $past(swp)) else $error("swap wrong");
  a_and_imm_zero: assert property (instr_valid && instr.op == mie_pkg::OP_ADD && instr.sel == 3'b101
    ##1 instr_take |-> acc == ($past(acc) & $past(instr.imm)) && null_result_flag == (acc == 8'h00)
    && $stable(msb_outflow_flag)) else $error("and wrong");
  a_table_pair_split: assert property (instr_valid && instr.op == mie_pkg::OP_TAB_PAGED ##1 instr_take
    |-> table_high_latch == $past(tw_hi) && mem_we && mem_wdata == $past(tw_lo) ##1 !instr_take)
    else $error("table read wrong");
endmodule
bind mie_core mie_core_monitor #(.PC_W(PC_W)) mon_u (.mclk, .sys_rst, .instr_valid, .instr,
  .mem_rdata, .table_word, .instr_take, .pc, .mem_we, .mem_wdata, .acc, .table_high_latch,
  .watchdog_counter_clr, .prescaler_clr, .sys_clk_run, .timeout_flag, .powerdown_flag,
  .null_result_flag, .msb_outflow_flag);

// >>> dv/mie_core_tb.sv
`timescale 1ns/1ns
module mie_core_tb;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic instr_valid = 1'b0;
  mie_pkg::mie_instr_t instr = '0;
  logic [7:0] table_ptr = 8'h00;
  logic [7:0] table_page = 8'h00;
  logic wake = 1'b0;
  logic [7:0] mem_rdata, mem_wdata, acc, table_high_latch, a;
  logic [15:0] table_word;
  logic [10:0] pc, table_addr, p;
  logic instr_take, mem_we, watchdog_counter_clr, prescaler_clr, global_irq_gate, sys_clk_run;
  logic timeout_flag, powerdown_flag, null_result_flag, msb_outflow_flag, half_carry_flag;
  logic overflow_flag;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  mie_core dut_u (.mclk, .sys_rst, .instr_valid, .instr, .mem_rdata, .table_word, .table_ptr,
    .table_page, .wake, .instr_take, .pc, .mem_we, .mem_wdata, .acc, .table_high_latch,
    .table_addr, .watchdog_counter_clr, .prescaler_clr, .global_irq_gate, .sys_clk_run,
    .timeout_flag, .powerdown_flag, .null_result_flag, .msb_outflow_flag, .half_carry_flag,
    .overflow_flag);
  mie_mem_model mem_u (.mclk, .instr, .mem_we, .mem_wdata, .table_ptr, .table_page, .mem_rdata,
    .table_word);
  // A 50 ns clock, and a cycle ceiling well above the roughly 125 cycles the run needs.
  initial begin
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("mismatches %0d of %0d checks", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk_b(input logic [7:0] g, input logic [7:0] e, input string m);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h want %h", $time, m, g, e);
    end
  endtask
  task automatic chk_p(input logic [10:0] g, input logic [10:0] e, input string m);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h want %h", $time, m, g, e);
    end
  endtask
  function automatic logic [7:0] fl();
    return {2'b00, overflow_flag, null_result_flag, half_carry_flag, msb_outflow_flag,
      timeout_flag, powerdown_flag};
  endfunction
  // One instruction; with nxt an immediate load is offered in the cycle after it is taken.
  task automatic exec(input mie_pkg::mie_op_t op, input logic [2:0] s, input logic [2:0] b,
    input logic [7:0] x, input logic [10:0] ad, input logic nxt);
    @(posedge mclk);
    instr_valid <= 1'b1;
    instr <= '{op: op, sel: mie_pkg::mie_alu_sel_t'(s), bit_idx: b, imm: x, addr: ad};
    @(posedge mclk);
    if (nxt) begin
      instr.op <= mie_pkg::OP_MOV_X2A;
      instr.imm <= 8'hee;
      @(posedge mclk);
    end
    instr_valid <= 1'b0;
    #1;
  endtask
  task automatic wake_up();
    @(posedge mclk);
    wake <= 1'b1;
    for (int i = 0; i < 20 && sys_clk_run !== 1'b1; i++) @(posedge mclk);
    wake <= 1'b0;
    chk_b({7'h00, sys_clk_run}, 8'h01, "wake");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_move();
    exec(mie_pkg::OP_MOV_M2A, 3'h0, 3'h0, 8'h00, 11'h033, 1'b0);
    chk_b(acc, 8'h33, "load");
    exec(mie_pkg::OP_MOV_A2M, 3'h0, 3'h0, 8'h00, 11'h020, 1'b0);
    chk_b({7'h00, mem_we}, 8'h01, "store");
    exec(mie_pkg::OP_MOV_X2A, 3'h0, 3'h0, 8'h7f, 11'h000, 1'b0);
    exec(mie_pkg::OP_MOV_M2A, 3'h0, 3'h0, 8'h00, 11'h020, 1'b0);
    chk_b(acc, 8'h33, "reload");
    chk_b(fl(), 8'h00, "flags");
  endtask
  task automatic t_bits();
    exec(mie_pkg::OP_BIT_SET, 3'h0, 3'h7, 8'h00, 11'h010, 1'b0);
    chk_b(mem_wdata, 8'h90, "bit set");
    exec(mie_pkg::OP_BIT_CLR, 3'h0, 3'h4, 8'h00, 11'h010, 1'b0);
    chk_b(mem_wdata, 8'h80, "bit clr");
    exec(mie_pkg::OP_BYTE_CLR, 3'h0, 3'h0, 8'h00, 11'h005, 1'b0);
    chk_b(mem_wdata, 8'h00, "byte clr");
    exec(mie_pkg::OP_BYTE_SET, 3'h0, 3'h0, 8'h00, 11'h006, 1'b0);
    chk_b(mem_wdata, 8'hff, "byte set");
    exec(mie_pkg::OP_SWAP, 3'h0, 3'h0, 8'h00, 11'h012, 1'b0);
    chk_b(mem_wdata, 8'h21, "swap");
    exec(mie_pkg::OP_SWAP_A, 3'h0, 3'h0, 8'h00, 11'h034, 1'b0);
    chk_b(acc, 8'h43, "swap acc");
  endtask
  task automatic t_alu();
    exec(mie_pkg::OP_MOV_X2A, 3'h0, 3'h0, 8'h7f, 11'h000, 1'b0);
    exec(mie_pkg::OP_ADD, 3'b100, 3'h0, 8'h01, 11'h000, 1'b0);
    chk_b(fl(), 8'h28, "add ovf");
    exec(mie_pkg::OP_ADD, 3'b100, 3'h0, 8'h80, 11'h000, 1'b0);
    chk_b(fl(), 8'h34, "add carry");
    exec(mie_pkg::OP_MOV_X2A, 3'h0, 3'h0, 8'h0f, 11'h000, 1'b0);
    exec(mie_pkg::OP_ADD, 3'b101, 3'h0, 8'h3c, 11'h000, 1'b0);
    chk_b(fl(), 8'h24, "and");
    exec(mie_pkg::OP_ADC, 3'b000, 3'h0, 8'h00, 11'h001, 1'b0);
    chk_b(acc, 8'h0e, "adc acc");
    exec(mie_pkg::OP_ADC, 3'b010, 3'h0, 8'h00, 11'h003, 1'b0);
    chk_b(mem_wdata, 8'h11, "adc mem");
    chk_b(fl(), 8'h08, "adc half");
    exec(mie_pkg::OP_ADD, 3'b010, 3'h0, 8'h00, 11'h020, 1'b0);
    chk_b(mem_wdata, 8'h41, "add mem");
    exec(mie_pkg::OP_ADD, 3'b011, 3'h0, 8'h00, 11'h034, 1'b0);
    chk_b(mem_wdata, 8'h04, "and mem");
  endtask
  task automatic t_flow();
    p = pc;
    a = acc;
    exec(mie_pkg::OP_CALL, 3'h0, 3'h0, 8'h00, 11'h123, 1'b1);
    chk_p(pc, 11'h123, "call");
    chk_b(acc, a, "dummy");
    exec(mie_pkg::OP_GOTO, 3'h0, 3'h0, 8'h00, 11'h200, 1'b1);
    chk_p(pc, 11'h200, "goto");
    exec(mie_pkg::OP_INTERRUPT_EXIT, 3'h0, 3'h0, 8'h00, 11'h000, 1'b0);
    chk_p(pc, p + 11'h001, "interrupt_exit");
    chk_b({7'h00, global_irq_gate}, 8'h01, "gate");
    p = pc;
    exec(mie_pkg::OP_SKZ, 3'h0, 3'h0, 8'h00, 11'h005, 1'b1);
    chk_p(pc, p + 11'h002, "skip");
    chk_b({7'h00, instr_take}, 8'h00, "skip dummy");
    exec(mie_pkg::OP_SKZ, 3'h0, 3'h0, 8'h00, 11'h007, 1'b1);
    chk_b(acc, 8'hee, "no skip");
    p = pc;
    exec(mie_pkg::OP_SKB_SET, 3'h0, 3'h0, 8'h00, 11'h007, 1'b0);
    chk_p(pc, p + 11'h002, "bit skip");
    p = pc;
    exec(mie_pkg::OP_INC_SKZ_A, 3'h0, 3'h0, 8'h00, 11'h006, 1'b0);
    chk_p(pc, p + 11'h002, "inc skip");
    chk_b(acc, 8'h00, "inc acc");
    exec(mie_pkg::OP_DEC_SKZ, 3'h0, 3'h0, 8'h00, 11'h001, 1'b0);
    chk_b(mem_wdata, 8'h00, "dec mem");
    exec(mie_pkg::OP_MOV_M2A, 3'h0, 3'h0, 8'h00, 11'h006, 1'b0);
    chk_b(acc, 8'hff, "acc form");
    exec(mie_pkg::OP_SKB_CLR, 3'h0, 3'h0, 8'h00, 11'h007, 1'b1);
    chk_b(acc, 8'hee, "bit no skip");
    p = pc;
    exec(mie_pkg::OP_SKZ_COPY, 3'h0, 3'h0, 8'h00, 11'h005, 1'b0);
    chk_p(pc, p + 11'h002, "copy skip");
    chk_b(acc, 8'h00, "copy acc");
    exec(mie_pkg::OP_INC_SKZ, 3'h0, 3'h0, 8'h00, 11'h010, 1'b0);
    chk_b(mem_wdata, 8'h81, "inc mem");
    exec(mie_pkg::OP_DEC_SKZ_A, 3'h0, 3'h0, 8'h00, 11'h012, 1'b0);
    chk_b(acc, 8'h20, "dec acc");
    p = pc;
    exec(mie_pkg::OP_IDLE, 3'h0, 3'h0, 8'h00, 11'h000, 1'b0);
    chk_p(pc, p + 11'h001, "idle");
    exec(mie_pkg::OP_CALL, 3'h0, 3'h0, 8'h00, 11'h300, 1'b0);
    exec(mie_pkg::OP_RET_X, 3'h0, 3'h0, 8'h5a, 11'h000, 1'b0);
    chk_p(pc, p + 11'h002, "ret acc");
    chk_b(acc, 8'h5a, "ret imm");
    exec(mie_pkg::OP_CALL, 3'h0, 3'h0, 8'h00, 11'h300, 1'b0);
    exec(mie_pkg::OP_RET, 3'h0, 3'h0, 8'h00, 11'h000, 1'b0);
    chk_p(pc, p + 11'h003, "ret");
  endtask
  task automatic t_table();
    @(posedge mclk);
    table_ptr <= 8'h3c;
    table_page <= 8'h01;
    exec(mie_pkg::OP_TAB_PAGED, 3'h0, 3'h0, 8'h00, 11'h040, 1'b0);
    chk_b(table_high_latch, 8'h5b, "latch");
    chk_p(table_addr, 11'h13c, "paged addr");
    exec(mie_pkg::OP_MOV_M2A, 3'h0, 3'h0, 8'h00, 11'h040, 1'b0);
    chk_b(acc, 8'hc3, "low byte");
    exec(mie_pkg::OP_TAB_LAST, 3'h0, 3'h0, 8'h00, 11'h041, 1'b0);
    chk_p(table_addr, 11'h73c, "last addr");
    p = pc;
    exec(mie_pkg::OP_TAB_CUR, 3'h0, 3'h0, 8'h00, 11'h041, 1'b0);
    chk_p(table_addr, {p[10:8], 8'h3c}, "cur addr");
  endtask
  task automatic t_power();
    exec(mie_pkg::OP_HALT, 3'h0, 3'h0, 8'h00, 11'h000, 1'b0);
    chk_b({6'h00, timeout_flag, powerdown_flag}, 8'h01, "halt");
    wake_up();
    exec(mie_pkg::OP_WDT_PRE_A, 3'h0, 3'h0, 8'h00, 11'h000, 1'b0);
    exec(mie_pkg::OP_WDT_PRE_A, 3'h0, 3'h0, 8'h00, 11'h000, 1'b0);
    chk_b({7'h00, powerdown_flag}, 8'h01, "repeat");
    exec(mie_pkg::OP_WDT_PRE_B, 3'h0, 3'h0, 8'h00, 11'h000, 1'b0);
    chk_b({7'h00, powerdown_flag}, 8'h00, "alternate");
    exec(mie_pkg::OP_HALT, 3'h0, 3'h0, 8'h00, 11'h000, 1'b0);
    wake_up();
    exec(mie_pkg::OP_WDT_CLR, 3'h0, 3'h0, 8'h00, 11'h000, 1'b0);
    chk_b({6'h00, watchdog_counter_clr, powerdown_flag}, 8'h02, "wdt clr");
  endtask
  // Reset for 16 cycles, then every scenario in turn.
  initial begin
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    t_move();
    t_bits();
    t_alu();
    t_flow();
    t_table();
    t_power();
    give_verdict();
  end
endmodule
